// >>> logic/cxysel_params.svh
// Purpose: constants for the core x/y line select decoder
// Assumes: included by bare name
// Notes: definitions only
`ifndef CXYSEL_PARAMS_SVH
`define CXYSEL_PARAMS_SVH
`define CXYSEL_ADDR_W 13
`define CXYSEL_WORDS_8K 8192
`define CXYSEL_WORDS_4K 4096
`define CXYSEL_XSW_DEC_8K 4
`define CXYSEL_XSW_DEC_4K 2
`define CXYSEL_YSW_DEC 2
`define CXYSEL_DRV_DEC 2
`define CXYSEL_OUTS 8
`define CXYSEL_RESET_ADDR 13'h0000
`endif

// >>> logic/cxysel_pkg.sv
// Purpose: shared types for the core x/y line select decoder
// Assumes: nothing
// Notes: types only; numbers live in the params header
package cxysel_pkg;
  typedef logic [3:0] cxysel_dec_in_t;
  typedef logic [7:0] cxysel_dec_out_t;
  typedef enum logic [1:0] {
    CXYSEL_CFG_4K = 2'h1,
    CXYSEL_CFG_8K = 2'h2
  } cxysel_cfg_e;
endpackage

// >>> logic/cxysel_dec_if.sv
// Purpose: carries one decoder's four weighted inputs and eight outputs
// Assumes: one instance per one-of-eight decoder
// Notes: outputs are active low
`timescale 1ns/1ps
`default_nettype none
interface cxysel_dec_if;
  cxysel_pkg::cxysel_dec_in_t din;
  cxysel_pkg::cxysel_dec_out_t dout_b;
  modport ctl (output din, input dout_b);
  modport dec (input din, output dout_b);
endinterface
`default_nettype wire

// >>> logic/cxysel_dec8.sv
// Purpose: one-of-eight decoder, inputs weighted 1,2,4,8
// Assumes: combinational, same clock domain as caller
// Notes: codes 8..15 leave every output high (block disabled)
`timescale 1ns/1ps
`default_nettype none
module cxysel_dec8 (
  cxysel_dec_if.dec d
);
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_out
      // only the output whose index equals the code goes low
      assign d.dout_b[g] = !((d.din[3] == 1'b0) &&
        (d.din[2:0] == 3'(g)));
    end
  endgenerate
endmodule
`default_nettype wire

// >>> logic/cxysel_top.sv
// Purpose: word address register and x/y switch and driver line select
// Assumes: strobes and read state are synchronous to mclk_i
// Notes: switch and driver outputs active low; low turns a switch or driver on; driver_timing_enable_o is active high
`timescale 1ns/1ps
`default_nettype none
`include "cxysel_params.svh"
module cxysel_top (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic cfg_8k_i,
  input wire logic addr_load_i,
  input wire logic [12:0] word_addr_i,
  input wire logic read_b_i,
  input wire logic select_strobe_i,
  input wire logic write_inhibit_delay_strobe_i,
  input wire logic no_access_read_strobe_i,
  output logic driver_timing_enable_o,
  output logic [15:0] x_read_sw_b_o,
  output logic [15:0] x_write_sw_b_o,
  output logic [7:0] x_read_drv_b_o,
  output logic [7:0] x_write_drv_b_o,
  output logic [7:0] y_read_sw_b_o,
  output logic [7:0] y_write_sw_b_o,
  output logic [7:0] y_read_drv_b_o,
  output logic [7:0] y_write_drv_b_o
);
  localparam int NDEC = 10;
  // decoder slots: 0..3 X switches, 4..5 X drivers,
  // 6..7 Y switches, 8..9 Y drivers
  logic [`CXYSEL_ADDR_W-1:0] addr_q;
  logic read_state;
  logic timing_en;
  logic [NDEC-1:0] blk_en_b;
  logic [NDEC-1:0][7:0] dec_out_b;
  logic [NDEC-1:0][3:0] dec_in;
  logic [1:0] x_sw_sel;
  logic drv_x_sel;
  logic sw_y_sel;
  logic drv_y_sel;
  logic x_sw_gate;
  logic [15:0] xrs_d, xws_d, yrs_d, yws_d;
  logic [7:0] xrd_d, xwd_d, yrd_d, ywd_d;

  // word address register; loaded on the control clock qualifier only,
  // no functional set or clear beyond power-on reset
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_q <= `CXYSEL_RESET_ADDR;
    end else if (addr_load_i) begin
      addr_q <= word_addr_i;
    end
  end

  assign read_state = !read_b_i;

  // driver timing enable from read/write state and timing strobes
  assign timing_en = (read_state && write_inhibit_delay_strobe_i) ||
    (!read_state && no_access_read_strobe_i);

  // block groups: A12/A13 pick one of four X switch decoders in 8K,
  // A13 is forced high in 4K so only two X switch groups exist
  always_comb begin
    x_sw_sel = cfg_8k_i ? {addr_q[12], addr_q[11]} : {1'b1, addr_q[11]};
    drv_x_sel = addr_q[2];
    sw_y_sel = addr_q[5];
    drv_y_sel = addr_q[8];
  end

  // 4K leaves two X switch decoders unused, halving the X matrix
  assign x_sw_gate = select_strobe_i;

  genvar g;
  generate
    for (g = 0; g < NDEC; g++) begin : g_dec
      cxysel_dec_if dif ();
      cxysel_dec8 u_dec (
        .d(dif.dec)
      );
      assign dif.din = dec_in[g];
      assign dec_out_b[g] = dif.dout_b;
    end
  endgenerate

  // block enables; X switches span four groups in 8K
  always_comb begin
    blk_en_b = '1;
    for (int k = 0; k < 4; k++) begin
      if (x_sw_gate && (x_sw_sel == 2'(k)) &&
          (cfg_8k_i || k >= 2)) begin
        blk_en_b[k] = 1'b0;
      end
    end
    // driver decoders: enable NAND timing, so low only when timing high; Y switch decoders 6..7 NAND x_sw_gate instead
    blk_en_b[4] = !(timing_en && !drv_x_sel);
    blk_en_b[5] = !(timing_en && drv_x_sel);
    blk_en_b[6] = !(x_sw_gate && !sw_y_sel);
    blk_en_b[7] = !(x_sw_gate && sw_y_sel);
    blk_en_b[8] = !(timing_en && !drv_y_sel);
    blk_en_b[9] = !(timing_en && drv_y_sel);
  end

  // read_b drives weight 4 of every decoder low bits pick
  // one of four within the half
  always_comb begin
    for (int k = 0; k < NDEC; k++) begin
      dec_in[k] = {blk_en_b[k], read_b_i, 2'b00};
    end
    for (int k = 0; k < 4; k++) begin
      dec_in[k][1:0] = {addr_q[10], addr_q[9]};
    end
    dec_in[4][1:0] = {addr_q[1], addr_q[0]};
    dec_in[5][1:0] = {addr_q[1], addr_q[0]};
    dec_in[6][1:0] = {addr_q[4], addr_q[3]};
    dec_in[7][1:0] = {addr_q[4], addr_q[3]};
    dec_in[8][1:0] = {addr_q[7], addr_q[6]};
    dec_in[9][1:0] = {addr_q[7], addr_q[6]};
  end

  // map decoder outputs to devices: 0-3 read, 4-7 write; read turns on
  // positive read driver and negative read switch, write the reverse
  always_comb begin
    xrs_d = '1;
    xws_d = '1;
    for (int k = 0; k < 4; k++) begin
      xrs_d[k*4 +: 4] = dec_out_b[k][3:0];
      xws_d[k*4 +: 4] = dec_out_b[k][7:4];
    end
    xrd_d = {dec_out_b[5][3:0], dec_out_b[4][3:0]};
    xwd_d = {dec_out_b[5][7:4], dec_out_b[4][7:4]};
    yrs_d = {8'hFF, dec_out_b[7][3:0], dec_out_b[6][3:0]};
    yws_d = {8'hFF, dec_out_b[7][7:4], dec_out_b[6][7:4]};
    yrd_d = {dec_out_b[9][3:0], dec_out_b[8][3:0]};
    ywd_d = {dec_out_b[9][7:4], dec_out_b[8][7:4]};
  end

  // registered outputs, low = device on, high = off all decoders
  // are one-hot so one switch and one driver per axis at most
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      x_read_sw_b_o <= 16'hFFFF;
      x_write_sw_b_o <= 16'hFFFF;
      x_read_drv_b_o <= 8'hFF;
      x_write_drv_b_o <= 8'hFF;
      y_read_sw_b_o <= 8'hFF;
      y_write_sw_b_o <= 8'hFF;
      y_read_drv_b_o <= 8'hFF;
      y_write_drv_b_o <= 8'hFF;
      driver_timing_enable_o <= 1'b0;
    end else begin
      x_read_sw_b_o <= xrs_d;
      x_write_sw_b_o <= xws_d;
      x_read_drv_b_o <= xrd_d;
      x_write_drv_b_o <= xwd_d;
      y_read_sw_b_o <= yrs_d[7:0];
      y_write_sw_b_o <= yws_d[7:0];
      y_read_drv_b_o <= yrd_d;
      y_write_drv_b_o <= ywd_d;
      driver_timing_enable_o <= timing_en;
    end
  end
endmodule
`default_nettype wire

// >>> tb/cxysel_stack_model.sv
// Purpose: core stack switch and driver transistors
// Assumes: inputs active low, low turns a transistor on
// Notes: flags read and write current at the same time
`timescale 1ns/1ps
`default_nettype none
module cxysel_stack_model (
  input wire logic [39:0] rd_b_i,
  input wire logic [39:0] wr_b_i,
  output logic fault_o
);
  // both directions at once would cancel the half-select current
  assign fault_o = !(&rd_b_i) && !(&wr_b_i);
endmodule
`default_nettype wire

// >>> tb/cxysel_properties.sv
// Purpose: port checks for the line select decoder
// Assumes: outputs follow inputs after one edge
// Notes: bound to cxysel_top
`timescale 1ns/1ps
`default_nettype none
module cxysel_properties (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic read_b_i,
  input wire logic select_strobe_i,
  input wire logic write_inhibit_delay_strobe_i,
  input wire logic no_access_read_strobe_i,
  input wire logic driver_timing_enable_o,
  input wire logic [15:0] x_read_sw_b_o,
  input wire logic [15:0] x_write_sw_b_o,
  input wire logic [7:0] x_read_drv_b_o,
  input wire logic [7:0] x_write_drv_b_o,
  input wire logic [7:0] y_read_sw_b_o,
  input wire logic [7:0] y_write_sw_b_o,
  input wire logic [7:0] y_read_drv_b_o,
  input wire logic [7:0] y_write_drv_b_o
);
  wire [31:0] xs = {x_read_sw_b_o, x_write_sw_b_o};
  wire [15:0] ys = {y_read_sw_b_o, y_write_sw_b_o};
  wire [15:0] xd = {x_read_drv_b_o, x_write_drv_b_o};
  wire [15:0] yd = {y_read_drv_b_o, y_write_drv_b_o};
  wire te = read_b_i ? no_access_read_strobe_i
                     : write_inhibit_delay_strobe_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  property p_te; 1 |=> driver_timing_enable_o == $past(te); endproperty
  property p_sw_off; !select_strobe_i |=> &{xs, ys}; endproperty
  property p_xs; select_strobe_i |=> $onehot(~xs); endproperty
  property p_ys; select_strobe_i |=> $onehot(~ys); endproperty
  property p_dr_off; !driver_timing_enable_o |-> &{xd, yd}; endproperty
  property p_dr_on;
    driver_timing_enable_o |-> $onehot(~xd) && $onehot(~yd);
  endproperty
  property p_rd; !read_b_i |=> &{xs[15:0], ys[7:0], xd[7:0], yd[7:0]};
  endproperty
  property p_wr; read_b_i |=> &{xs[31:16], ys[15:8], xd[15:8], yd[15:8]};
  endproperty
  a_te: assert property (p_te) else $error("bad enable");
  a_sw_off: assert property (p_sw_off) else $error("switch on");
  a_xs: assert property (p_xs) else $error("x switch count");
  a_ys: assert property (p_ys) else $error("y switch count");
  a_dr_off: assert property (p_dr_off) else $error("driver on");
  a_dr_on: assert property (p_dr_on) else $error("driver count");
  a_rd: assert property (p_rd) else $error("write half on");
  a_wr: assert property (p_wr) else $error("read half on");
  c_rd: cover property (!read_b_i && select_strobe_i);
  c_wr: cover property (read_b_i && select_strobe_i);
  c_off: cover property (!driver_timing_enable_o);
endmodule
bind cxysel_top cxysel_properties i_cxysel_properties (.*);
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for the line select decoder
// Assumes: load edge, then strobe edge per access
// Notes: expectations rebuilt from the address field layout
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk_i = 0, rst_b_i = 0, cfg_8k_i = 1, addr_load_i = 0;
  logic read_b_i = 0, select_strobe_i = 0, fault;
  logic write_inhibit_delay_strobe_i = 0, no_access_read_strobe_i = 0;
  logic [12:0] word_addr_i = 13'h0000;
  logic driver_timing_enable_o;
  logic [15:0] x_read_sw_b_o, x_write_sw_b_o;
  logic [7:0] x_read_drv_b_o, x_write_drv_b_o, y_read_sw_b_o;
  logic [7:0] y_write_sw_b_o, y_read_drv_b_o, y_write_drv_b_o;
  logic [39:0] rd, wr;
  int mismatches = 0, checks = 0;
  assign rd = {x_read_sw_b_o,x_read_drv_b_o,y_read_sw_b_o,y_read_drv_b_o};
  assign wr = {x_write_sw_b_o,x_write_drv_b_o,y_write_sw_b_o,y_write_drv_b_o};
  cxysel_top i_cxysel_top (.*);
  cxysel_stack_model i_cxysel_stack_model (.rd_b_i(rd), .wr_b_i(wr),
    .fault_o(fault));
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic access(input logic [12:0] ad, input logic c8, rb, ss, w, n);
    logic [39:0] e;
    logic te;
    @(negedge mclk_i);
    addr_load_i = 1;
    word_addr_i = ad;
    cfg_8k_i = c8;
    @(negedge mclk_i);
    addr_load_i = 0;
    word_addr_i = ~ad;
    read_b_i = rb;
    select_strobe_i = ss;
    write_inhibit_delay_strobe_i = w;
    no_access_read_strobe_i = n;
    te = rb ? n : w;
    e = {~(16'(ss) << {c8 ? ad[12] : 1'b1, ad[11:9]}), ~(8'(te) << ad[2:0]),
      ~(8'(ss) << ad[5:3]), ~(8'(te) << ad[8:6])};
    @(negedge mclk_i);
    cmp({38'h0, driver_timing_enable_o, fault}, {38'h0, te, 1'b0});
    cmp(rb ? rd : wr, 40'hFFFFFFFFFF);
    cmp(rb ? wr : rd, e);
  endtask
  task automatic t_sweep;
    for (int i = 0; i < 32; i++) begin
      access({i[3], 12'(12'h249 * i[2:0])},
        1'b1, i[4], 1'b1, !i[4], i[4]);
    end
  endtask
  task automatic t_small;
    for (int i = 0; i < 8; i++) begin
      access({1'b0, 12'(12'h249 * i[2:0])},
        1'b0, i[0], 1'b1, 1'b1, 1'b1);
    end
  endtask
  task automatic t_gate;
    access(13'h1ABC, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    access(13'h0DEF, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
  endtask
  task results;
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial forever #5 mclk_i = ~mclk_i;
  initial begin
    repeat (5) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_b_i = 1;
    t_sweep;
    t_small;
    t_gate;
    results;
  end
  initial begin
    #20000;
    mismatches++;
    results;
  end
endmodule
`default_nettype wire
